// >>> hdl/demod_loop_pkg.sv
// Constants for the QPSK demodulator loop control block.
// Assumes an 8-bit internal register address space behind the serial host port.
package demod_loop_pkg;
  // ***************
  // Register map
  // ***************
  localparam logic [7:0] ADDR_CTRL_ONE  = 8'h80;
  localparam logic [7:0] ADDR_CTRL_TWO  = 8'h81;
  localparam logic [7:0] ADDR_TGT_LOW   = 8'h82;
  localparam logic [7:0] ADDR_TGT_HIGH  = 8'h83;
  localparam logic [7:0] ADDR_IF_SHIFT  = 8'h84;
  localparam logic [7:0] ADDR_IF_INTG   = 8'h85;
  localparam logic [7:0] ADDR_AMP_TGT   = 8'h86;
  localparam logic [7:0] ADDR_AMP_SHIFT = 8'h87;
  localparam logic [7:0] ADDR_AMP_INTG  = 8'h88;
  localparam logic [7:0] ADDR_RAMP      = 8'h95;
  localparam logic [7:0] ADDR_FLAG      = 8'h99;
  localparam logic [7:0] ADDR_NOISE     = 8'h9a;
  // ***************
  // Reset values
  // ***************
  localparam logic [7:0] RST_CTRL_ONE  = 8'h10;
  localparam logic [7:0] RST_CTRL_TWO  = 8'h90;
  localparam logic [9:0] RST_TGT       = 10'h106;
  localparam logic [2:0] RST_SHIFT     = 3'h0;
  localparam logic [5:0] RST_AMP_TGT   = 6'h16;
  localparam logic [5:0] RST_RAMP      = 6'h01;
  // ***************
  // Fields
  // ***************
  localparam int         POL_BIT     = 6;
  localparam int         PFD_LSB     = 4;
  localparam int         SCAT_LSB    = 2;
  localparam int         IVAL_LSB    = 0;
  localparam int         SWEEP_BIT   = 5;
  localparam int         STEP_BIT    = 4;
  localparam logic [2:0] SHIFT_OPEN  = 3'h7;
  localparam logic [1:0] SCAT_OFF    = 2'h3;
  localparam logic [8:0] SCAT_THR0   = 9'h008;
  localparam logic [8:0] SCAT_THR1   = 9'h00c;
  localparam logic [8:0] SCAT_THR2   = 9'h010;
  localparam logic [16:0] IVAL_LEN0  = 17'h00400;
  localparam logic [16:0] IVAL_LEN1  = 17'h01000;
  localparam logic [16:0] IVAL_LEN2  = 17'h04000;
  localparam logic [16:0] IVAL_LEN3  = 17'h10000;
  localparam logic [9:0] NOISE_MAX   = 10'h3ff;
endpackage

// >>> hdl/qpsk_demod_loop_control.sv
// Carrier detector, sweep ramp, IF and amplitude gain loops, lock and noise indicator.
// Assumes symbol samples, power samples and the lock level come from sys_clk logic.
// How it works
// - Phase error per symbol is I times sign Q minus Q times sign I.
// - Error updates only when both magnitudes exceed threshold, else holds.
// - Threshold is upper nibble of control register two, reset 0x90.
// - Sweep-on bit enables ramp; when clear the ramp output is zero.
// - Ramp steps two to the step bit every divider plus one clocks.
// - Carrier lock disables the sweep whatever the sweep-on bit says.
// - IF loop integrates target minus power, scaled by its shift.
// - IF integrator becomes a pulse-width signal on the gain pin.
// - IF integrator top byte readable and writable; write clears lower bits.
// - Polarity bit inverts the IF loop sign.
// - IF loop gain is two to the shift; code 111 gives zero.
// - Ten-bit IF target spans two byte registers, reset 262.
// - Amplitude loop integrates target minus output modulus, scaled by shift.
// - Amplitude integrator drives the I and Q output multipliers.
// - Amplitude gain two to the shift; 111 freezes the multiplier gain.
// - Six-bit amplitude target is the desired output modulus directly.
// - Active-low lock indicator on a pin and in the flag register.
// - Ten-bit scatter counter; its top byte loads the result each interval.
// - Scatter threshold codes select 8, 12, 16; code 11 disables.
// - Interval codes select 1024, 4096, 16384 or 65536 symbols.
// - Result-ready flag sets when a new noise count is loaded.
`timescale 1ns/1ns
module qpsk_demod_loop_control #(
  parameter int SAMP_W     = 8,
  parameter int POW_W      = 10,
  parameter int IF_INTG_W  = 18,
  parameter int AMP_INTG_W = 16,
  parameter int RAMP_W     = 24
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  // Internal register port
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_we,
  input  wire logic                     reg_re,
  output logic      [7:0]               reg_rdata,
  // Nyquist filter output, power estimate and carrier lock
  input  wire logic                     sym_valid,
  input  wire logic signed [SAMP_W-1:0] sym_i,
  input  wire logic signed [SAMP_W-1:0] sym_q,
  input  wire logic                     if_power_valid,
  input  wire logic [POW_W-1:0]         if_power,
  input  wire logic                     carrier_lock,
  // Loop outputs
  output logic signed [SAMP_W+1:0]      phase_error,
  output logic      [RAMP_W-1:0]        sweep_ramp,
  output logic                          agc_pwm,
  output logic                          lock_n,
  output logic      [7:0]               amp_gain
);
  import demod_loop_pkg::*;
  localparam int PE_W = SAMP_W + 2;
  localparam int IE_W = POW_W + 1;

  function automatic logic [SAMP_W-1:0] mag(input logic signed [SAMP_W-1:0] v);
    mag = v[SAMP_W-1] ? SAMP_W'(-v) : SAMP_W'(v);
  endfunction

  // ***************
  // State
  // ***************
  logic [7:0]            ctrl_one, ctrl_two, next_ctrl_one, next_ctrl_two;
  logic [9:0]            if_tgt, next_if_tgt;
  logic [2:0]            if_shift, amp_shift, next_if_shift, next_amp_shift;
  logic [5:0]            amp_tgt, ramp_ctrl, next_amp_tgt, next_ramp_ctrl;
  logic [IF_INTG_W-1:0]  if_intg, next_if_intg;
  logic [AMP_INTG_W-1:0] amp_intg, next_amp_intg;
  logic [3:0]            div_cnt, next_div_cnt;
  logic [7:0]            pwm_cnt, duty, next_pwm_cnt, next_duty;
  logic [15:0]           sym_cnt, next_sym_cnt;
  logic [9:0]            scat_cnt, next_scat_cnt;
  logic [7:0]            noise_count_value, next_noise_count_value;
  logic                  noise_result_ready, next_noise_result_ready;
  logic [7:0]            next_rdata, next_amp_gain;
  logic signed [PE_W-1:0] next_phase_error, eps;
  logic [RAMP_W-1:0]     next_sweep_ramp;
  logic                  next_agc_pwm;

  // ***************
  // Datapath terms
  // ***************
  logic [SAMP_W-1:0]     mag_i, mag_q, mx, mn;
  logic                  pe_upd, ramp_on, interval_end, wr_if, wr_amp;
  logic [3:0]            phase_detector_threshold;
  logic [SAMP_W:0]       modulus;
  logic [8:0]            scat_thr, scatter;
  logic [16:0]           interval_len;
  logic signed [IE_W-1:0]       if_err;
  logic signed [IE_W+5:0]       if_scaled;
  logic signed [IF_INTG_W:0]    if_sum;
  logic signed [SAMP_W+1:0]     amp_err;
  logic signed [SAMP_W+7:0]     amp_scaled;
  logic signed [AMP_INTG_W:0]   amp_sum;

  always_comb begin
    mag_i = mag(sym_i);
    mag_q = mag(sym_q);
    phase_detector_threshold = ctrl_two[PFD_LSB +: 4];
    // Zero counts as positive sign
    eps = (sym_q[SAMP_W-1] ? -PE_W'(sym_i) : PE_W'(sym_i))
        - (sym_i[SAMP_W-1] ? -PE_W'(sym_q) : PE_W'(sym_q));
    pe_upd = sym_valid && (mag_i > SAMP_W'(phase_detector_threshold))
             && (mag_q > SAMP_W'(phase_detector_threshold));
    ramp_on = ramp_ctrl[SWEEP_BIT] && !carrier_lock;
    wr_if = reg_we && reg_addr == ADDR_IF_INTG;
    wr_amp = reg_we && reg_addr == ADDR_AMP_INTG;
    // IF loop error, sign flipped for negative-slope amplifiers
    if_err = signed'(IE_W'(if_tgt)) - signed'(IE_W'(if_power));
    if (ctrl_one[POL_BIT]) begin
      if_err = -if_err;
    end
    if_scaled = (IE_W+6)'(if_err) <<< if_shift;
    if_sum = signed'((IF_INTG_W+1)'(signed'(if_intg))) + (IF_INTG_W+1)'(if_scaled);
    // Cheap modulus: max plus half of min
    mx = (mag_i > mag_q) ? mag_i : mag_q;
    mn = (mag_i > mag_q) ? mag_q : mag_i;
    modulus = (SAMP_W+1)'(mx) + (SAMP_W+1)'(mn >> 1);
    amp_err = signed'((SAMP_W+2)'(amp_tgt)) - signed'((SAMP_W+2)'(modulus));
    amp_scaled = (SAMP_W+8)'(amp_err) <<< amp_shift;
    amp_sum = signed'((AMP_INTG_W+1)'(signed'(amp_intg))) + (AMP_INTG_W+1)'(amp_scaled);
    // Noise estimator distance from the ideal constellation corner
    scatter = 9'((mag_i > SAMP_W'(amp_tgt)) ? mag_i - SAMP_W'(amp_tgt)
                                             : SAMP_W'(amp_tgt) - mag_i)
            + 9'((mag_q > SAMP_W'(amp_tgt)) ? mag_q - SAMP_W'(amp_tgt)
                                             : SAMP_W'(amp_tgt) - mag_q);
    unique case (ctrl_two[SCAT_LSB +: 2])
      2'h0: scat_thr = SCAT_THR0;
      2'h1: scat_thr = SCAT_THR1;
      default: scat_thr = SCAT_THR2;
    endcase
    unique case (ctrl_two[IVAL_LSB +: 2])
      2'h0: interval_len = IVAL_LEN0;
      2'h1: interval_len = IVAL_LEN1;
      2'h2: interval_len = IVAL_LEN2;
      default: interval_len = IVAL_LEN3;
    endcase
    interval_end = sym_valid && (17'(sym_cnt) == interval_len - 17'h1);
  end

  // ***************
  // Next state
  // ***************
  always_comb begin
    next_ctrl_one = ctrl_one;
    next_ctrl_two = ctrl_two;
    next_if_tgt = if_tgt;
    next_if_shift = if_shift;
    next_amp_tgt = amp_tgt;
    next_amp_shift = amp_shift;
    next_ramp_ctrl = ramp_ctrl;
    if (reg_we) begin
      unique case (reg_addr)
        ADDR_CTRL_ONE:  next_ctrl_one = reg_wdata;
        ADDR_CTRL_TWO:  next_ctrl_two = reg_wdata;
        ADDR_TGT_LOW:   next_if_tgt[7:0] = reg_wdata;
        ADDR_TGT_HIGH:  next_if_tgt[9:8] = reg_wdata[1:0];
        ADDR_IF_SHIFT:  next_if_shift = reg_wdata[2:0];
        ADDR_AMP_TGT:   next_amp_tgt = reg_wdata[5:0];
        ADDR_AMP_SHIFT: next_amp_shift = reg_wdata[2:0];
        ADDR_RAMP:      next_ramp_ctrl = reg_wdata[5:0];
        default: ;
      endcase
    end
    // Phase detector holds its last value between qualified symbols
    next_phase_error = pe_upd ? eps : phase_error;
    // Sweep ramp
    next_div_cnt = 4'h0;
    next_sweep_ramp = '0;
    if (ramp_on) begin
      next_div_cnt = div_cnt + 4'h1;
      next_sweep_ramp = sweep_ramp;
      if (div_cnt >= ramp_ctrl[3:0]) begin
        next_div_cnt = 4'h0;
        next_sweep_ramp = sweep_ramp + (RAMP_W'(1) << ramp_ctrl[STEP_BIT]);
      end
    end
    // IF gain loop with saturation; a write always wins
    next_if_intg = if_intg;
    if (wr_if) begin
      next_if_intg = {reg_wdata, (IF_INTG_W-8)'(0)};
    end else if (if_power_valid && if_shift != SHIFT_OPEN) begin
      if (if_sum[IF_INTG_W] != if_sum[IF_INTG_W-1]) begin
        next_if_intg = {if_sum[IF_INTG_W], {(IF_INTG_W-1){~if_sum[IF_INTG_W]}}};
      end else begin
        next_if_intg = if_sum[IF_INTG_W-1:0];
      end
    end
    // PWM: offset-binary duty latched once per period to avoid glitches
    next_pwm_cnt = pwm_cnt + 8'h1;
    next_duty = (pwm_cnt == 8'hff) ? {~if_intg[IF_INTG_W-1], if_intg[IF_INTG_W-2 -: 7]} : duty;
    next_agc_pwm = pwm_cnt < duty;
    // Amplitude loop
    next_amp_intg = amp_intg;
    if (wr_amp) begin
      next_amp_intg = {reg_wdata, (AMP_INTG_W-8)'(0)};
    end else if (sym_valid && amp_shift != SHIFT_OPEN) begin
      if (amp_sum[AMP_INTG_W] != amp_sum[AMP_INTG_W-1]) begin
        next_amp_intg = {amp_sum[AMP_INTG_W], {(AMP_INTG_W-1){~amp_sum[AMP_INTG_W]}}};
      end else begin
        next_amp_intg = amp_sum[AMP_INTG_W-1:0];
      end
    end
    next_amp_gain = amp_intg[AMP_INTG_W-1 -: 8];
    // Noise estimator; counter saturates so 255 reads as overflow
    next_sym_cnt = sym_cnt;
    next_scat_cnt = scat_cnt;
    next_noise_count_value = noise_count_value;
    next_noise_result_ready = noise_result_ready;
    if (reg_re && reg_addr == ADDR_NOISE) begin
      next_noise_result_ready = 1'b0;
    end
    if (sym_valid) begin
      next_sym_cnt = sym_cnt + 16'h1;
      if (ctrl_two[SCAT_LSB +: 2] != SCAT_OFF && scatter > scat_thr
          && scat_cnt != NOISE_MAX) begin
        next_scat_cnt = scat_cnt + 10'h1;
      end
      if (interval_end) begin
        next_noise_count_value = next_scat_cnt[9:2];
        next_sym_cnt = 16'h0;
        next_scat_cnt = 10'h0;
        next_noise_result_ready = 1'b1;
      end
    end
    // Register reads
    unique case (reg_addr)
      ADDR_CTRL_ONE:  next_rdata = ctrl_one;
      ADDR_CTRL_TWO:  next_rdata = ctrl_two;
      ADDR_TGT_LOW:   next_rdata = if_tgt[7:0];
      ADDR_TGT_HIGH:  next_rdata = {6'h0, if_tgt[9:8]};
      ADDR_IF_SHIFT:  next_rdata = {5'h0, if_shift};
      ADDR_IF_INTG:   next_rdata = if_intg[IF_INTG_W-1 -: 8];
      ADDR_AMP_TGT:   next_rdata = {2'h0, amp_tgt};
      ADDR_AMP_SHIFT: next_rdata = {5'h0, amp_shift};
      ADDR_AMP_INTG:  next_rdata = amp_intg[AMP_INTG_W-1 -: 8];
      ADDR_RAMP:      next_rdata = {2'h0, ramp_ctrl};
      ADDR_FLAG:      next_rdata = {lock_n, noise_result_ready, 6'h0};
      ADDR_NOISE:     next_rdata = noise_count_value;
      default:        next_rdata = 8'h0;
    endcase
    if (!reg_re) begin
      next_rdata = reg_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_one <= RST_CTRL_ONE;
      ctrl_two <= RST_CTRL_TWO;
      if_tgt <= RST_TGT;
      if_shift <= RST_SHIFT;
      amp_tgt <= RST_AMP_TGT;
      amp_shift <= RST_SHIFT;
      ramp_ctrl <= RST_RAMP;
      if_intg <= '0;
      amp_intg <= '0;
      div_cnt <= 4'h0;
      pwm_cnt <= 8'h0;
      duty <= 8'h0;
      sym_cnt <= 16'h0;
      scat_cnt <= 10'h0;
      noise_count_value <= 8'h0;
      noise_result_ready <= 1'b0;
      reg_rdata <= 8'h0;
      phase_error <= '0;
      sweep_ramp <= '0;
      agc_pwm <= 1'b0;
      lock_n <= 1'b1;
      amp_gain <= 8'h0;
    end else begin
      ctrl_one <= next_ctrl_one;
      ctrl_two <= next_ctrl_two;
      if_tgt <= next_if_tgt;
      if_shift <= next_if_shift;
      amp_tgt <= next_amp_tgt;
      amp_shift <= next_amp_shift;
      ramp_ctrl <= next_ramp_ctrl;
      if_intg <= next_if_intg;
      amp_intg <= next_amp_intg;
      div_cnt <= next_div_cnt;
      pwm_cnt <= next_pwm_cnt;
      duty <= next_duty;
      sym_cnt <= next_sym_cnt;
      scat_cnt <= next_scat_cnt;
      noise_count_value <= next_noise_count_value;
      noise_result_ready <= next_noise_result_ready;
      reg_rdata <= next_rdata;
      phase_error <= next_phase_error;
      sweep_ramp <= next_sweep_ramp;
      agc_pwm <= next_agc_pwm;
      lock_n <= ~carrier_lock;
      amp_gain <= next_amp_gain;
    end
  end

  // ***************
  // Checks
  // ***************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  pe_hold_a: assert property (sym_valid && !pe_upd |=> $stable(phase_error))
    else $error("phase error changed without qualified symbol");
  pe_value_a: assert property (pe_upd |=> phase_error == $past(eps))
    else $error("phase error not taken from symbol");
  ramp_off_a: assert property (!ramp_ctrl[SWEEP_BIT] |=> sweep_ramp == '0)
    else $error("ramp not zero while sweep off");
  ramp_lock_a: assert property (carrier_lock |=> sweep_ramp == '0)
    else $error("ramp running while locked");
  ramp_step_a: assert property (ramp_on && $past(ramp_on) && !reg_we |=>
    sweep_ramp == $past(sweep_ramp) ||
    sweep_ramp == $past(sweep_ramp) + (RAMP_W'(1) << ramp_ctrl[STEP_BIT]))
    else $error("ramp step size wrong");
  if_write_a: assert property (wr_if |=> if_intg == {$past(reg_wdata), (IF_INTG_W-8)'(0)})
    else $error("integrator write not loaded");
  if_open_a: assert property (if_shift == SHIFT_OPEN && !wr_if |=> $stable(if_intg))
    else $error("open IF loop moved");
  amp_freeze_a: assert property (amp_shift == SHIFT_OPEN && !wr_amp ##1 1'b1 |=>
    $stable(amp_gain))
    else $error("frozen amplitude gain moved");
  lock_pin_a: assert property (##1 lock_n == !$past(carrier_lock))
    else $error("lock pin mismatch");
  noise_flag_a: assert property (interval_end |=> noise_result_ready)
    else $error("noise ready not set");
  ramp_run_c: cover property (ramp_on ##1 sweep_ramp != '0);
  noise_done_c: cover property (interval_end ##1 noise_count_value != 8'h0);
  if_write_c: cover property (wr_if ##1 if_power_valid);
  pe_upd_c: cover property (pe_upd ##1 pe_upd);
endmodule

// >>> test/vga_filter_model.sv
// Averaging model of the RC filter and gain amplifier on the gain pin.
// Assumes the pin changes on sys_clk; one measurement spans 256 cycles.
`timescale 1ns/1ns
module vga_filter_model (
  // Clock
  input  wire logic       sys_clk,
  // Gain pin and measurement control
  input  wire logic       agc_pwm,
  input  wire logic       measure_start,
  output logic      [8:0] high_count,
  output logic            measuring
);
  logic [8:0] window;
  // Window equals the pulse period, so any phase sees the whole duty
  always_ff @(posedge sys_clk) begin
    if (measure_start) begin
      window     <= 9'h100;
      high_count <= 9'h000;
    end else if (window != 9'h000) begin
      window     <= window - 9'h001;
      high_count <= high_count + {8'h00, agc_pwm};
    end
  end
  assign measuring = (window != 9'h000);
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the demodulator loop control block.
// Assumes read data appears one cycle after the read strobe edge.
`timescale 1ns/1ns
module tb_top;
  import demod_loop_pkg::*;
  localparam int DLY = 10;
  int                mismatches = 0;
  int                comparisons = 0;
  int                nsym = 0;
  logic              sys_clk = 1'b0;
  logic              srst = 1'b1;
  logic [7:0]        reg_addr = 8'h00;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_we = 1'b0;
  logic              reg_re = 1'b0;
  logic [7:0]        reg_rdata;
  logic              sym_valid = 1'b0;
  logic signed [7:0] sym_i = 8'sh00;
  logic signed [7:0] sym_q = 8'sh00;
  logic              if_power_valid = 1'b0;
  logic [9:0]        if_power = 10'h000;
  logic              carrier_lock = 1'b0;
  logic signed [9:0] phase_error;
  logic [23:0]       sweep_ramp;
  logic              agc_pwm;
  logic              lock_n;
  logic [7:0]        amp_gain;
  logic              measure_start = 1'b0;
  logic [8:0]        high_count;
  logic [7:0]        v;
  logic [7:0]        ra [12] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86,
                                 8'h87, 8'h88, 8'h95, 8'h99, 8'h70};
  logic [7:0]        rv [12] = '{RST_CTRL_ONE, RST_CTRL_TWO, 8'h06, 8'h01, 8'h00, 8'h00,
                                 8'h16, 8'h00, 8'h00, 8'h01, 8'h80, 8'h00};
  logic [7:0]        nexp [4] = '{8'h50, 8'h46, 8'h32, 8'h00};

  qpsk_demod_loop_control i_qpsk_demod_loop_control (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .sym_valid(sym_valid),
    .sym_i(sym_i), .sym_q(sym_q), .if_power_valid(if_power_valid), .if_power(if_power),
    .carrier_lock(carrier_lock), .phase_error(phase_error), .sweep_ramp(sweep_ramp),
    .agc_pwm(agc_pwm), .lock_n(lock_n), .amp_gain(amp_gain)
  );
  vga_filter_model i_vga_filter_model (
    .sys_clk(sys_clk), .agc_pwm(agc_pwm), .measure_start(measure_start),
    .high_count(high_count), .measuring()
  );

  always #50 sys_clk = ~sys_clk;

  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #DLY;
    reg_we = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #DLY;
    reg_we = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    #DLY;
    reg_re = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #DLY;
    reg_re = 1'b0;
    check(reg_rdata, e);
  endtask
  task automatic sym(input int n, input logic signed [7:0] i, input logic signed [7:0] q);
    @(posedge sys_clk);
    #DLY;
    sym_valid = 1'b1;
    sym_i = i;
    sym_q = q;
    repeat (n) @(posedge sys_clk);
    #DLY;
    sym_valid = 1'b0;
    nsym += n;
  endtask
  task automatic pwr(input logic [9:0] p);
    @(posedge sys_clk);
    #DLY;
    if_power_valid = 1'b1;
    if_power = p;
    @(posedge sys_clk);
    #DLY;
    if_power_valid = 1'b0;
  endtask
  task automatic ramp_chk(input logic [23:0] e);
    logic [23:0] s;
    s = sweep_ramp;
    repeat (8) @(posedge sys_clk);
    #DLY;
    check(sweep_ramp - s, e);
  endtask

  // ****************
  // Tests
  // ****************
  initial begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    #DLY;
    srst = 1'b0;
    for (int k = 0; k < 12; k++) rchk(ra[k], rv[k]);
    sym(1, 8'sd20, -8'sd30);
    check(phase_error, 10'sd10);
    sym(1, 8'sd5, 8'sd40);
    check(phase_error, 10'sd10);
    sym(1, -8'sd40, -8'sd10);
    check(phase_error, 10'sd30);
    wr(ADDR_CTRL_TWO, 8'h20);
    sym(1, 8'sd5, 8'sd40);
    check(phase_error, -10'sd35);
    wr(ADDR_CTRL_TWO, 8'h90);
    check(sweep_ramp, 24'h0);
    wr(ADDR_RAMP, 8'h20);
    ramp_chk(24'd8);
    wr(ADDR_RAMP, 8'h33);
    ramp_chk(24'd4);
    @(posedge sys_clk);
    #DLY;
    carrier_lock = 1'b1;
    repeat (2) @(posedge sys_clk);
    #DLY;
    check(sweep_ramp, 24'h0);
    check(lock_n, 24'h0);
    ramp_chk(24'd0);
    rchk(ADDR_FLAG, 8'h00);
    carrier_lock = 1'b0;
    wr(ADDR_RAMP, 8'h13);
    repeat (2) @(posedge sys_clk);
    #DLY;
    check(sweep_ramp, 24'h0);
    // Open loop first so the pin duty reflects only the written byte
    wr(ADDR_IF_SHIFT, 8'h07);
    wr(ADDR_IF_INTG, 8'h40);
    rchk(ADDR_IF_INTG, 8'h40);
    pwr(10'd6);
    rchk(ADDR_IF_INTG, 8'h40);
    repeat (600) @(posedge sys_clk);
    #DLY;
    measure_start = 1'b1;
    @(posedge sys_clk);
    #DLY;
    measure_start = 1'b0;
    repeat (260) @(posedge sys_clk);
    #DLY;
    check(high_count, 9'd192);
    wr(ADDR_IF_INTG, 8'h00);
    wr(ADDR_IF_SHIFT, 8'h02);
    pwr(10'd6);
    rchk(ADDR_IF_INTG, 8'h01);
    wr(ADDR_IF_SHIFT, 8'h05);
    pwr(10'd6);
    rchk(ADDR_IF_INTG, 8'h09);
    wr(ADDR_CTRL_ONE, 8'h50);
    pwr(10'd6);
    rchk(ADDR_IF_INTG, 8'h01);
    wr(ADDR_CTRL_ONE, 8'h10);
    wr(ADDR_TGT_LOW, 8'h00);
    wr(ADDR_TGT_HIGH, 8'h02);
    wr(ADDR_IF_SHIFT, 8'h01);
    pwr(10'd0);
    rchk(ADDR_IF_INTG, 8'h02);
    wr(ADDR_AMP_SHIFT, 8'h07);
    wr(ADDR_AMP_INTG, 8'h00);
    wr(ADDR_AMP_SHIFT, 8'h06);
    sym(1, 8'sd22, 8'sd0);
    rchk(ADDR_AMP_INTG, 8'h00);
    wr(ADDR_AMP_TGT, 8'h20);
    wr(ADDR_AMP_SHIFT, 8'h03);
    sym(1, 8'sd0, 8'sd0);
    rchk(ADDR_AMP_INTG, 8'h01);
    wr(ADDR_AMP_SHIFT, 8'h06);
    sym(1, 8'sd0, 8'sd0);
    rchk(ADDR_AMP_INTG, 8'h09);
    check(amp_gain, 8'h09);
    wr(ADDR_AMP_SHIFT, 8'h07);
    sym(4, 8'sd0, 8'sd0);
    rchk(ADDR_AMP_INTG, 8'h09);
    check(amp_gain, 8'h09);
    // Symbols since reset are counted, so pad to an interval edge
    wr(ADDR_AMP_TGT, 8'h10);
    if (nsym % 1024 != 0) sym(1024 - nsym % 1024, 8'sd16, 8'sd16);
    // Eleven earlier symbols scattered past the threshold, so the first result is 2
    v = 8'h02;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL_TWO, {4'h9, 2'(c), 2'b00});
      rchk(ADDR_NOISE, v);
      sym(40, 8'sd22, 8'sd22);
      sym(80, 8'sd24, 8'sd24);
      sym(200, 8'sd28, 8'sd28);
      sym(704, 8'sd16, 8'sd16);
      rchk(ADDR_FLAG, 8'hc0);
      rchk(ADDR_NOISE, nexp[c]);
      v = nexp[c];
    end
    wr(ADDR_CTRL_TWO, 8'h91);
    sym(4095, 8'sd28, 8'sd28);
    rchk(ADDR_FLAG, 8'h80);
    sym(1, 8'sd28, 8'sd28);
    rchk(ADDR_FLAG, 8'hc0);
    rchk(ADDR_NOISE, 8'hff);
    finish_test();
  end
endmodule
